/* File: src/tic_top.sv */
// Time interval counter: timebase chain, interval match and register port.
module tic_top (
   input  wire logic        core_clk_in,
   input  wire logic        reset_in,
   input  wire logic        xtal_clk_in,
   input  wire logic        power_down_in,
   input  wire logic        irq_enable_in,
   input  wire logic [7:0]  sfr_addr_in,
   input  wire logic        sfr_wr_in,
   input  wire logic        sfr_rd_in,
   input  wire logic [7:0]  sfr_wdata_in,
   output logic [7:0]       sfr_rdata_out,
   output logic             irq_out,
   output logic             wake_out,
   output logic [15:0]      wake_vector_out
);
   import tic_pkg::*;

   typedef struct packed {
      logic        xtal_prev;
      logic [7:0]  presc;
      logic        hour_wrap;
      logic [1:0]  rate;
      logic        one_shot;
      logic        flag;
      logic        irun;
      logic        trun;
      logic [7:0]  sh_frac;
      logic [7:0]  sh_sec;
      logic [7:0]  sh_min;
      logic [7:0]  sh_hour;
      logic [7:0]  target;
      logic [7:0]  icnt;
      logic [7:0]  rdata;
      logic        irq;
      logic        wake;
      logic [15:0] vec;
   } tic_state_s;

   tic_state_s s_q;
   tic_state_s s_d;

   logic       xtal_sync;
   logic       tick;
   logic       wr_ctrl;
   logic       wr_time;
   logic       time_load;
   logic       ovf_sel;
   logic       match_ev;
   logic [7:0] icnt_next;
   logic [7:0] hour_max;
   logic [7:0] frac_cnt;
   logic [7:0] sec_cnt;
   logic [7:0] min_cnt;
   logic [7:0] hour_cnt;
   logic       frac_wrap;
   logic       sec_wrap;
   logic       min_wrap;
   logic [7:0] ld_frac;
   logic [7:0] ld_sec;
   logic [7:0] ld_min;
   logic [7:0] ld_hour;

   // Pick the write data for one time register when it is addressed, else its shadow
   function automatic logic [7:0] load_pick(input logic [7:0] addr,
                                            input logic [7:0] shadow);
      return (sfr_wr_in && sfr_addr_in == addr) ? sfr_wdata_in : shadow;
   endfunction

   tic_sync u_xtal_sync (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .async_in    (xtal_clk_in),
      .sync_out    (xtal_sync)
   );

   // 1/128 s tick from crystal edges, never gated by power-down
   assign tick = s_q.trun && xtal_sync && !s_q.xtal_prev && (s_q.presc == PRESC_MAX);

   // Register write decode
   assign wr_ctrl = sfr_wr_in && (sfr_addr_in == ADDR_CONTROL);
   assign wr_time = sfr_wr_in && !s_q.trun
                    && (sfr_addr_in >= ADDR_FRACTION) && (sfr_addr_in <= ADDR_HOUR);

   // while stopped the counters hold the last written values
   // written values reach counters only while stopped
   assign time_load = !s_q.trun || wr_time;
   assign ld_frac   = s_q.trun ? s_q.sh_frac : load_pick(ADDR_FRACTION, s_q.sh_frac);
   assign ld_sec    = s_q.trun ? s_q.sh_sec  : load_pick(ADDR_ONE_HZ, s_q.sh_sec);
   assign ld_min    = s_q.trun ? s_q.sh_min  : load_pick(ADDR_SIXTY_S, s_q.sh_min);
   assign ld_hour   = s_q.trun ? s_q.sh_hour : load_pick(ADDR_HOUR, s_q.sh_hour);

   assign hour_max = s_q.hour_wrap ? HOUR_MAX_24 : HOUR_MAX_256;

   tic_wrap_cnt #(.W(8)) u_frac (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .step_in     (tick),
      .load_in     (time_load),
      .load_val_in (ld_frac),
      .max_in      (FRACTION_MAX),
      .count_out   (frac_cnt),
      .wrap_out    (frac_wrap)
   );

   tic_wrap_cnt #(.W(8)) u_sec (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .step_in     (frac_wrap),
      .load_in     (time_load),
      .load_val_in (ld_sec),
      .max_in      (SIXTY_MAX),
      .count_out   (sec_cnt),
      .wrap_out    (sec_wrap)
   );

   tic_wrap_cnt #(.W(8)) u_min (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .step_in     (sec_wrap),
      .load_in     (time_load),
      .load_val_in (ld_min),
      .max_in      (SIXTY_MAX),
      .count_out   (min_cnt),
      .wrap_out    (min_wrap)
   );

   // hours step on minutes rollover and wrap at the selected top
   tic_wrap_cnt #(.W(8)) u_hour (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .step_in     (min_wrap),
      .load_in     (time_load),
      .load_val_in (ld_hour),
      .max_in      (hour_max),
      .count_out   (hour_cnt),
      // Hour rollover feeds nothing further up, so its carry stays open
      .wrap_out    ()
   );

   // overflow that clocks the interval counter
   // Each unit is the carry out of the register below it, so 1/128 s is the tick itself
   // and hours are the minutes rollover; intervals then reach 256 hours at the top, with target 0
   always_comb begin
      unique case (s_q.rate)
         RATE_FRACTION: ovf_sel = tick;
         RATE_SECONDS:  ovf_sel = frac_wrap;
         RATE_MINUTES:  ovf_sel = sec_wrap;
         RATE_HOURS:    ovf_sel = min_wrap;
      endcase
   end

   // match when the advanced count equals the target
   assign icnt_next = 8'(s_q.icnt + 1'b1);
   assign match_ev  = s_q.irun && ovf_sel && (icnt_next == s_q.target);

   // Next state: software writes first, hardware events after so a set wins
   always_comb begin
      s_d     = s_q;
      s_d.vec = WAKE_VECTOR;
      if (xtal_sync && !s_q.xtal_prev && s_q.trun) begin
         s_d.presc = (s_q.presc == PRESC_MAX) ? RESET_BYTE : 8'(s_q.presc + 1'b1);
      end
      s_d.xtal_prev = xtal_sync;
      // Stopped timebase restarts a full 1/128 s on enable
      if (!s_q.trun) begin
         s_d.presc = RESET_BYTE;
      end
      if (wr_ctrl) begin
         s_d.hour_wrap = sfr_wdata_in[BIT_HOUR_WRAP];
         s_d.rate      = {sfr_wdata_in[BIT_RATE_HI], sfr_wdata_in[BIT_RATE_LO]};
         s_d.one_shot  = sfr_wdata_in[BIT_ONE_SHOT];
         s_d.flag      = sfr_wdata_in[BIT_FLAG];
         s_d.irun      = sfr_wdata_in[BIT_INT_RUN];
         s_d.trun      = sfr_wdata_in[BIT_TIMEBASE];
      end
      if (sfr_wr_in && sfr_addr_in == ADDR_TARGET) begin
         s_d.target = sfr_wdata_in;
      end
      // shadows keep the last software value
      if (wr_time) begin
         unique case (sfr_addr_in)
            ADDR_FRACTION: s_d.sh_frac = sfr_wdata_in;
            ADDR_ONE_HZ:   s_d.sh_sec  = sfr_wdata_in;
            ADDR_SIXTY_S:  s_d.sh_min  = sfr_wdata_in;
            default:       s_d.sh_hour = sfr_wdata_in;
         endcase
      end
      if (s_q.irun && ovf_sel) begin
         s_d.icnt = icnt_next;
      end
      if (match_ev) begin
         // sticky flag, set beats a same-cycle clear
         s_d.flag = 1'b1;
         s_d.icnt = RESET_BYTE;
         if (s_q.one_shot) begin
            s_d.irun = 1'b0;
         end
      end
      // disabled counter sits at zero so the next run starts there
      if (!s_d.irun || (wr_ctrl && !s_q.irun)) begin
         s_d.icnt = RESET_BYTE;
      end
      // interrupt request follows the flag when enabled
      s_d.irq  = s_q.flag && irq_enable_in;
      // wake pulse on a match in power-down
      s_d.wake = match_ev && power_down_in && irq_enable_in;
      if (sfr_rd_in) begin
         unique case (sfr_addr_in)
            ADDR_CONTROL:  s_d.rdata = {1'b0, s_q.hour_wrap, s_q.rate, s_q.one_shot,
                                        s_q.flag, s_q.irun, s_q.trun};
            ADDR_FRACTION: s_d.rdata = frac_cnt;
            ADDR_ONE_HZ:   s_d.rdata = sec_cnt;
            ADDR_SIXTY_S:  s_d.rdata = min_cnt;
            ADDR_HOUR:     s_d.rdata = hour_cnt;
            ADDR_TARGET:   s_d.rdata = s_q.target;
            default:       s_d.rdata = RESET_BYTE;
         endcase
      end
   end

   // Single state register; all outputs come from it
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sfr_rdata_out   = s_q.rdata;
   assign irq_out         = s_q.irq;
   assign wake_out        = s_q.wake;
   assign wake_vector_out = s_q.vec;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);

   sequence power_down_match;
      match_ev && power_down_in && irq_enable_in;
   endsequence

   sequence wake_pulse;
      wake_out && (wake_vector_out == WAKE_VECTOR) ##1 !wake_out;
   endsequence

   flag_set_a: assert property (match_ev |=> s_q.flag)
      else $error("match did not set the flag");
   flag_hold_a: assert property (s_q.flag && !wr_ctrl |=> s_q.flag)
      else $error("flag dropped without a software clear");
   irq_follow_a: assert property (s_q.flag && irq_enable_in |=> irq_out)
      else $error("enabled flag did not raise the interrupt");
   wake_seq_a: assert property (power_down_match |=> wake_pulse)
      else $error("power-down match did not wake to the vector");
   one_shot_a: assert property (match_ev && s_q.one_shot |=> !s_q.irun)
      else $error("single interval did not stop the counter");
   reload_a: assert property (match_ev && !s_q.one_shot && !wr_ctrl
                              |=> s_q.irun && s_q.icnt == RESET_BYTE)
      else $error("auto reload failed");
   idle_zero_a: assert property (!s_q.irun |-> s_q.icnt == RESET_BYTE)
      else $error("stopped interval counter not at zero");
   stop_hold_a: assert property (!s_q.trun && !sfr_wr_in |=> frac_cnt == s_q.sh_frac
                                 && hour_cnt == s_q.sh_hour)
      else $error("stopped time registers differ from written values");
   frac_range_a: assert property (s_q.trun && $past(s_q.trun) |-> frac_cnt <= FRACTION_MAX)
      else $error("fraction count out of range");
   sec_carry_a: assert property (frac_wrap |=> sec_cnt != $past(sec_cnt))
      else $error("seconds missed a fraction rollover");
   hour_top_a: assert property (s_q.hour_wrap && hour_cnt == HOUR_MAX_24 && min_wrap
                                |=> hour_cnt == RESET_BYTE)
      else $error("hour did not wrap at the day top");
   run_gate_a: assert property (!s_q.trun |-> !(frac_wrap || sec_wrap || min_wrap))
      else $error("time register carried while timebase stopped");

   hour_full_a: assert property (!s_q.hour_wrap && hour_cnt == HOUR_MAX_256 && min_wrap
                                 |=> hour_cnt == RESET_BYTE)
      else $error("hour did not wrap at the long top");
   min_carry_a: assert property (sec_wrap |=> min_cnt != $past(min_cnt))
      else $error("minutes missed a seconds rollover");
   frac_step_a: assert property (tick && frac_cnt < FRACTION_MAX
                                 |=> frac_cnt == 8'($past(frac_cnt) + 8'h01))
      else $error("fraction did not step on a tick");
   icnt_step_a: assert property (s_q.irun && ovf_sel && !match_ev && !wr_ctrl
                                 |=> s_q.icnt == 8'($past(s_q.icnt) + 8'h01))
      else $error("interval counter did not advance");
endmodule

/* File: src/tic_pkg.sv */
// Constants, register map and field layout of the time interval counter.
// Behaviour
// - Whole counter is timed from the 32.768 kHz crystal and runs through power-down.
// - Rate select bits 5:4 pick which time register overflow advances the interval.
// - Interval count equal to target sets sticky match flag bit 2, raising interrupt.
// - Match during power-down with interrupt enabled wakes device to vector 0053H.
// - One-shot bit 3 set makes a timeout clear the interval run bit.
// - One-shot bit clear reloads the interval counter at every timeout.
// - Interval run bit 1 enables or disables the 8-bit interval counter.
// - Timebase run bit 0 gates ticks; clearing restores last written time values.
// - Time registers take writes only while timebase run is low.
// - Hour wrap bit 6 set counts hours 0 to 23, else 0 to 255.
// - Fraction counts 0 to 127 each 1/128 s, rollover steps seconds.
// - Seconds count 0 to 59, rollover steps minutes.
// - Minutes count 0 to 59, rollover steps hours.
// - Target holds any value 0 to 255 and the compare uses it.
package tic_pkg;
   localparam logic [7:0]  ADDR_CONTROL    = 8'hA1;
   localparam logic [7:0]  ADDR_FRACTION   = 8'hA2;
   localparam logic [7:0]  ADDR_ONE_HZ     = 8'hA3;
   localparam logic [7:0]  ADDR_SIXTY_S    = 8'hA4;
   localparam logic [7:0]  ADDR_HOUR       = 8'hA5;
   localparam logic [7:0]  ADDR_TARGET     = 8'hA6;
   localparam logic [7:0]  RESET_BYTE      = 8'h00;
   localparam int          BIT_TIMEBASE    = 0;
   localparam int          BIT_INT_RUN     = 1;
   localparam int          BIT_FLAG        = 2;
   localparam int          BIT_ONE_SHOT    = 3;
   localparam int          BIT_RATE_LO     = 4;
   localparam int          BIT_RATE_HI     = 5;
   localparam int          BIT_HOUR_WRAP   = 6;
   localparam int          XTAL_HZ         = 32768;
   localparam int          FRACTION_HZ     = 128;
   localparam int          XTAL_PER_FRAC   = XTAL_HZ / FRACTION_HZ;
   localparam logic [7:0]  PRESC_MAX       = 8'(XTAL_PER_FRAC - 1);
   localparam logic [7:0]  FRACTION_MAX    = 8'h7F;
   localparam logic [7:0]  SIXTY_MAX       = 8'h3B;
   localparam logic [7:0]  HOUR_MAX_24     = 8'h17;
   localparam logic [7:0]  HOUR_MAX_256    = 8'hFF;
   localparam logic [15:0] WAKE_VECTOR     = 16'h0053;
   localparam logic [1:0]  RATE_FRACTION   = 2'h0;
   localparam logic [1:0]  RATE_SECONDS    = 2'h1;
   localparam logic [1:0]  RATE_MINUTES    = 2'h2;
   localparam logic [1:0]  RATE_HOURS      = 2'h3;
endpackage

/* File: src/tic_sync.sv */
// Two-stage synchroniser for a level coming from outside the core clock domain.
module tic_sync (
   input  wire logic core_clk_in,
   input  wire logic reset_in,
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed {
      logic meta;
      logic stable;
   } tic_sync_s;

   tic_sync_s s_q;
   tic_sync_s s_d;

   // First stage feeds only the second stage
   always_comb begin
      s_d.meta   = async_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.stable;
endmodule

/* File: src/tic_wrap_cnt.sv */
// Wrapping time counter with load, programmable top value and rollover carry.
module tic_wrap_cnt #(
   parameter int W = 8
) (
   input  wire logic         core_clk_in,
   input  wire logic         reset_in,
   input  wire logic         step_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] load_val_in,
   input  wire logic [W-1:0] max_in,
   output logic [W-1:0]      count_out,
   output logic              wrap_out
);
   typedef struct packed {
      logic [W-1:0] count;
   } tic_cnt_s;

   tic_cnt_s s_q;
   tic_cnt_s s_d;

   // Carry is combinational so a whole chain rolls over in one cycle
   assign wrap_out = step_in && !load_in && (s_q.count >= max_in);

   // Load beats counting; values above the top fold back to zero
   always_comb begin
      s_d = s_q;
      if (load_in) begin
         s_d.count = load_val_in;
      end else if (step_in) begin
         s_d.count = (s_q.count >= max_in) ? '0 : W'(s_q.count + 1'b1);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count_out = s_q.count;
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the time interval counter: register port, time chain and interval.
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tic_pkg::*;

   logic        core_clk_in;
   logic        reset_in;
   logic        xtal_clk_in;
   logic        power_down_in;
   logic        irq_enable_in;
   logic [7:0]  sfr_addr_in;
   logic        sfr_wr_in;
   logic        sfr_rd_in;
   logic [7:0]  sfr_wdata_in;
   logic [7:0]  sfr_rdata_out;
   logic        irq_out;
   logic        wake_out;
   logic [15:0] wake_vector_out;
   int          n_errors;
   int          tests_run;
   int          cycles;
   int          wake_cnt;
   integer      seed;

   tic_top uut (
      .core_clk_in     (core_clk_in),
      .reset_in        (reset_in),
      .xtal_clk_in     (xtal_clk_in),
      .power_down_in   (power_down_in),
      .irq_enable_in   (irq_enable_in),
      .sfr_addr_in     (sfr_addr_in),
      .sfr_wr_in       (sfr_wr_in),
      .sfr_rd_in       (sfr_rd_in),
      .sfr_wdata_in    (sfr_wdata_in),
      .sfr_rdata_out   (sfr_rdata_out),
      .irq_out         (irq_out),
      .wake_out        (wake_out),
      .wake_vector_out (wake_vector_out)
   );

   // Core clock, 40 ns period
   always #20 core_clk_in = ~core_clk_in;

   // Wake is a one-cycle pulse, so it is counted at every edge rather than sampled late
   always @(posedge core_clk_in) begin
      if (!reset_in && wake_out === 1'b1) wake_cnt++;
   end

   // Hang guard, well above the roughly 20000 cycles the tests need
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // settle before use
   // Bus tasks are entered 1 ns after an edge and return at the same offset
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_in  = a;
      sfr_wdata_in = d;
      sfr_wr_in    = 1'b1;
      @(posedge core_clk_in); #1;
      sfr_wr_in = 1'b0;
      // Idle edge so the strobe never drops and rises in one time step
      @(posedge core_clk_in); #1;
   endtask

   // Waits one extra edge so the registered read data has surely landed
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      sfr_addr_in = a;
      sfr_rd_in   = 1'b1;
      @(posedge core_clk_in); #1;
      sfr_rd_in = 1'b0;
      @(posedge core_clk_in); #1;
      `CHK($sformatf("register %h", a), e, sfr_rdata_out)
   endtask

   // Slow clock toggles every 2 core cycles; 256 rising edges make one 1/128 s tick
   task automatic tick(input int n);
      repeat (512 * n) begin
         repeat (2) @(posedge core_clk_in);
         #1;
         xtal_clk_in = ~xtal_clk_in;
      end
      repeat (12) @(posedge core_clk_in);
      #1;
   endtask

   // Half the time the top value, so rollovers are common
   function automatic logic [7:0] rnd_lim(input logic [7:0] mx);
      if ($random(seed) & 1) return mx;
      return 8'($unsigned($random(seed)) % (mx + 1));
   endfunction

   // One tick of the chain: {overflow per rate select, fraction, seconds, minutes, hour}
   function automatic logic [35:0] step_time(input logic [7:0] f, s, m, h, input logic wrap);
      logic cf, cs, cm;
      cf = (f == FRACTION_MAX);
      cs = cf && (s == SIXTY_MAX);
      cm = cs && (m == SIXTY_MAX);
      f  = cf ? 8'h00 : f + 8'h01;
      if (cf) s = (s == SIXTY_MAX) ? 8'h00 : s + 8'h01;
      if (cs) m = (m == SIXTY_MAX) ? 8'h00 : m + 8'h01;
      if (cm) h = ((wrap && h == HOUR_MAX_24) || h == HOUR_MAX_256) ? 8'h00 : h + 8'h01;
      return {cm, cs, cf, 1'b1, f, s, m, h};
   endfunction

   initial begin
      logic [7:0]  pf, ps, pm, ph, ctrl;
      logic [1:0]  rate;
      logic        wrap, ev;
      logic [35:0] exp;
      seed = 32'h0B4E;
      core_clk_in = 1'b0; reset_in = 1'b1; xtal_clk_in = 1'b0; power_down_in = 1'b0;
      irq_enable_in = 1'b0; sfr_addr_in = 8'h00; sfr_wr_in = 1'b0; sfr_rd_in = 1'b0;
      sfr_wdata_in = 8'h00; n_errors = 0; tests_run = 0; cycles = 0; wake_cnt = 0;
      repeat (6) @(posedge core_clk_in);
      #1;
      reset_in = 1'b0;
      // Reset values, unmapped neighbours read as zero
      for (int a = 8'hA0; a <= 8'hA7; a++) rd_chk(8'(a), RESET_BYTE);
      `CHK("wake vector", WAKE_VECTOR, wake_vector_out)
      wr(ADDR_CONTROL, 8'h80);
      rd_chk(ADDR_CONTROL, 8'h00);
      $display("test reset and map done");
      // Random preloads, every rate select, one-shot interval of one step
      for (int i = 0; i < 12; i++) begin
         rate = 2'(i);
         wrap = 1'($random(seed));
         irq_enable_in = 1'($random(seed));
         pf = rnd_lim(FRACTION_MAX);
         ps = rnd_lim(SIXTY_MAX);
         pm = rnd_lim(SIXTY_MAX);
         ph = wrap ? rnd_lim(HOUR_MAX_24) : (i[2] ? HOUR_MAX_24 : rnd_lim(HOUR_MAX_256));
         // Corner: full carry chain into each hour top, on the hours rate
         if (i == 7 || i == 11) begin
            wrap = i[3];
            pf = FRACTION_MAX;
            ps = SIXTY_MAX;
            pm = SIXTY_MAX;
            ph = wrap ? HOUR_MAX_24 : HOUR_MAX_256;
         end
         wr(ADDR_FRACTION, pf);
         wr(ADDR_ONE_HZ, ps);
         wr(ADDR_SIXTY_S, pm);
         wr(ADDR_HOUR, ph);
         wr(ADDR_TARGET, 8'h01);
         ctrl = {1'b0, wrap, rate, 4'hB};
         wr(ADDR_CONTROL, ctrl);
         wr(ADDR_FRACTION, ~pf);
         exp = step_time(pf, ps, pm, ph, wrap);
         ev = exp[32 + rate];
         tick(1);
         rd_chk(ADDR_FRACTION, exp[31:24]);
         rd_chk(ADDR_ONE_HZ, exp[23:16]);
         rd_chk(ADDR_SIXTY_S, exp[15:8]);
         rd_chk(ADDR_HOUR, exp[7:0]);
         rd_chk(ADDR_CONTROL, {1'b0, wrap, rate, 1'b1, ev, ~ev, 1'b1});
         `CHK("irq", ev & irq_enable_in, irq_out)
         wr(ADDR_CONTROL, 8'h00);
         rd_chk(ADDR_FRACTION, pf);
         rd_chk(ADDR_ONE_HZ, ps);
         rd_chk(ADDR_SIXTY_S, pm);
         rd_chk(ADDR_HOUR, ph);
      end
      `CHK("wake count", 0, wake_cnt)
      $display("test time chain and rate select done");
      // Auto reload with a longer target, then the same in power-down
      pf = 8'($unsigned($random(seed)));
      wr(ADDR_TARGET, pf);
      rd_chk(ADDR_TARGET, pf);
      for (int a = 8'hA2; a <= 8'hA5; a++) wr(8'(a), 8'h00);
      wr(ADDR_TARGET, 8'h03);
      irq_enable_in = 1'b1;
      wr(ADDR_CONTROL, 8'h03);
      tick(2);
      rd_chk(ADDR_CONTROL, 8'h03);
      tick(1);
      rd_chk(ADDR_CONTROL, 8'h07);
      `CHK("irq", 1'b1, irq_out)
      wr(ADDR_CONTROL, 8'h03);
      power_down_in = 1'b1;
      tick(2);
      rd_chk(ADDR_CONTROL, 8'h03);
      `CHK("wake count", 0, wake_cnt)
      tick(1);
      rd_chk(ADDR_CONTROL, 8'h07);
      `CHK("wake count", 1, wake_cnt)
      `CHK("wake vector", WAKE_VECTOR, wake_vector_out)
      rd_chk(ADDR_FRACTION, 8'h06);
      $display("test auto reload and wake done");
      // Reset in mid-run brings every register back to its reset value
      reset_in = 1'b1;
      repeat (3) @(posedge core_clk_in);
      #1;
      reset_in = 1'b0;
      rd_chk(ADDR_CONTROL, RESET_BYTE);
      rd_chk(ADDR_FRACTION, RESET_BYTE);
      rd_chk(ADDR_TARGET, RESET_BYTE);
      `CHK("irq after reset", 1'b0, irq_out)
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule
